// ==== inc/obcl_pkg.sv ====
// constants for the option byte configuration loader
// What this block does
// - boot settings come from flash byte 0080H
// - load automatically after every reset
// - settle wait 2^10/12/15/17 oscillator cycles
// - wait only for crystal/ceramic source
// - keep bit selects reset pin or input
// - low reset pin before load holds reset
// - clock source: 00 crystal, 01 external, 1x internal
// - crystal source takes both oscillator pins
// - external clock takes pin1, frees pin2
// - internal oscillator frees both pins
// - lock keeps slow oscillator running
// - unlocked stop request halts slow oscillator
// - locked forces watchdog clock to slow oscillator
// - unlocked: watchdog clock off in halt/stop
// - unlocked, other source: watchdog clock always off
// - running slow oscillator clocks timer h1 in stop
`default_nettype none
package obcl_pkg;
   localparam logic [15:0] OPT_ADDR = 16'h0080;
   localparam int SETTLE_HI = 6;
   localparam int SETTLE_LO = 5;
   localparam int KEEP_BIT = 3;
   localparam int SRC_HI = 2;
   localparam int SRC_LO = 1;
   localparam int LOCK_BIT = 0;
   localparam logic [7:0] OPT_RESET = 8'hFF;
   localparam int SETTLE_EXP0 = 10;
   localparam int SETTLE_EXP1 = 12;
   localparam int SETTLE_EXP2 = 15;
   localparam int SETTLE_EXP3 = 17;
   localparam int CNT_W = 18;
   localparam logic [1:0] SRC_XTAL = 2'b00;
   localparam logic [1:0] SRC_EXT = 2'b01;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_READ = 3'b001,
      ST_CAPT = 3'b011,
      ST_WAIT = 3'b010,
      ST_RUN = 3'b110
   } obcl_state_t;
endpackage
`default_nettype wire

// ==== rtl/obcl_top.sv ====
// option byte loader: fetch, decode, settle wait and clock/pin control
`default_nettype none
module obcl_top (
   input wire logic mclk,
   input wire logic rst,
   input wire logic reset_pin_raw,
   input wire logic osc_tick,
   input wire logic [7:0] flash_rdata,
   input wire logic flash_rvalid,
   input wire logic slow_osc_stop_request,
   input wire logic wdt_sel_slow,
   input wire logic cpu_halt,
   input wire logic cpu_stop,
   output logic [15:0] flash_addr,
   output logic flash_rd,
   output logic sys_reset,
   output logic load_done,
   output logic [1:0] settle_time_sel,
   output logic reset_pin_keep,
   output logic reset_pin_port_input,
   output logic [1:0] clk_source_sel,
   output logic xtal_en,
   output logic ext_clk_en,
   output logic int_osc_sel,
   output logic osc_pin1_port,
   output logic osc_pin2_port,
   output logic slow_osc_lock,
   output logic slow_osc_run,
   output logic wdt_clk_en,
   output logic wdt_force_slow,
   output logic tmh1_clk_en
);
   obcl_pkg::obcl_state_t state_r;
   logic [7:0] opt_r;
   logic [obcl_pkg::CNT_W-1:0] cnt_r;
   logic [2:0] pin_sync_r;
   logic pin_level_r;

   function automatic logic [obcl_pkg::CNT_W-1:0] settle_len(input logic [1:0] sel);
      case (sel)
         2'b00: settle_len = obcl_pkg::CNT_W'(1 << obcl_pkg::SETTLE_EXP0);
         2'b01: settle_len = obcl_pkg::CNT_W'(1 << obcl_pkg::SETTLE_EXP1);
         2'b10: settle_len = obcl_pkg::CNT_W'(1 << obcl_pkg::SETTLE_EXP2);
         default: settle_len = obcl_pkg::CNT_W'(1 << obcl_pkg::SETTLE_EXP3);
      endcase
   endfunction

   // three-stage pin synchroniser, change taken when stages two and three agree
   always_ff @(posedge mclk)
   begin
      pin_sync_r <= {pin_sync_r[1:0], reset_pin_raw};
      if (rst)
         pin_level_r <= 1'b1;
      else if (pin_sync_r[2] == pin_sync_r[1])
         pin_level_r <= pin_sync_r[2];
   end

   // low pin before the load finishes restarts the load; afterwards only if kept as reset
   logic pin_reset;
   assign pin_reset = !pin_level_r && (state_r != obcl_pkg::ST_RUN || opt_r[obcl_pkg::KEEP_BIT]);

   always_ff @(posedge mclk)
   begin
      if (rst || pin_reset)
      begin
         state_r <= obcl_pkg::ST_IDLE;
         opt_r <= obcl_pkg::OPT_RESET;
         cnt_r <= '0;
      end
      else
      begin
         case (state_r)
            obcl_pkg::ST_IDLE:
               state_r <= obcl_pkg::ST_READ;
            obcl_pkg::ST_READ:
               if (flash_rvalid)
               begin
                  opt_r <= flash_rdata;
                  state_r <= obcl_pkg::ST_CAPT;
               end
            obcl_pkg::ST_CAPT:
            begin
               cnt_r <= settle_len(opt_r[obcl_pkg::SETTLE_HI:obcl_pkg::SETTLE_LO]);
               // no wait unless the crystal source is chosen
               if (opt_r[obcl_pkg::SRC_HI:obcl_pkg::SRC_LO] == obcl_pkg::SRC_XTAL)
                  state_r <= obcl_pkg::ST_WAIT;
               else
                  state_r <= obcl_pkg::ST_RUN;
            end
            obcl_pkg::ST_WAIT:
               if (osc_tick)
               begin
                  if (cnt_r == obcl_pkg::CNT_W'(1))
                     state_r <= obcl_pkg::ST_RUN;
                  cnt_r <= cnt_r - obcl_pkg::CNT_W'(1);
               end
            obcl_pkg::ST_RUN:
               state_r <= obcl_pkg::ST_RUN;
            default:
               state_r <= obcl_pkg::ST_IDLE;
         endcase
      end
   end

   // flash fetch strobe
   always_ff @(posedge mclk)
   begin
      if (rst || pin_reset)
         flash_rd <= 1'b0;
      else
         flash_rd <= (state_r == obcl_pkg::ST_IDLE) ||
                     (state_r == obcl_pkg::ST_READ && !flash_rvalid);
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         flash_addr <= '0;
      else
         flash_addr <= obcl_pkg::OPT_ADDR;
   end

   // decoded outputs; pins stay in the safe default until the load is done
   logic run;
   logic [1:0] src;
   logic lock;
   assign run = (state_r == obcl_pkg::ST_RUN);
   assign src = opt_r[obcl_pkg::SRC_HI:obcl_pkg::SRC_LO];
   assign lock = opt_r[obcl_pkg::LOCK_BIT];

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         sys_reset <= 1'b1;
         load_done <= 1'b0;
         settle_time_sel <= 2'b11;
         reset_pin_keep <= 1'b1;
         reset_pin_port_input <= 1'b0;
         clk_source_sel <= 2'b11;
         xtal_en <= 1'b0;
         ext_clk_en <= 1'b0;
         int_osc_sel <= 1'b1;
         osc_pin1_port <= 1'b0;
         osc_pin2_port <= 1'b0;
      end
      else
      begin
         sys_reset <= !run || pin_reset;
         load_done <= run;
         settle_time_sel <= opt_r[obcl_pkg::SETTLE_HI:obcl_pkg::SETTLE_LO];
         reset_pin_keep <= opt_r[obcl_pkg::KEEP_BIT];
         reset_pin_port_input <= run && !opt_r[obcl_pkg::KEEP_BIT];
         clk_source_sel <= src;
         xtal_en <= (src == obcl_pkg::SRC_XTAL);
         ext_clk_en <= (src == obcl_pkg::SRC_EXT);
         int_osc_sel <= src[1];
         osc_pin1_port <= run && src[1];
         osc_pin2_port <= run && (src != obcl_pkg::SRC_XTAL);
      end
   end

   // slow oscillator and watchdog / timer h1 clock gating
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         slow_osc_lock <= 1'b1;
         slow_osc_run <= 1'b1;
         wdt_clk_en <= 1'b0;
         wdt_force_slow <= 1'b1;
         tmh1_clk_en <= 1'b0;
      end
      else
      begin
         slow_osc_lock <= lock;
         slow_osc_run <= lock || !slow_osc_stop_request;
         wdt_force_slow <= lock;
         if (lock)
            wdt_clk_en <= run;
         else
            wdt_clk_en <= run && wdt_sel_slow && !slow_osc_stop_request
                          && !cpu_halt && !cpu_stop;
         tmh1_clk_en <= run && (lock || !slow_osc_stop_request);
      end
   end

   // assertions
   decode_src_a: assert property (@(posedge mclk) disable iff (rst)
      run |=> clk_source_sel == $past(src) && int_osc_sel == $past(src[1]))
      else $error("clock source decode wrong");
   lock_run_a: assert property (@(posedge mclk) disable iff (rst)
      lock |=> slow_osc_run) else $error("locked slow oscillator stopped");
   stop_req_a: assert property (@(posedge mclk) disable iff (rst)
      !lock && slow_osc_stop_request |=> !slow_osc_run)
      else $error("stop request ignored");
   wdt_halt_a: assert property (@(posedge mclk) disable iff (rst)
      !lock && (cpu_halt || cpu_stop) |=> !wdt_clk_en)
      else $error("watchdog clock in halt");
   wdt_force_a: assert property (@(posedge mclk) disable iff (rst)
      lock |=> wdt_force_slow) else $error("watchdog not forced");
   no_wait_a: assert property (@(posedge mclk) disable iff (rst || pin_reset)
      state_r == obcl_pkg::ST_CAPT && src != obcl_pkg::SRC_XTAL |=> run)
      else $error("wait inserted for non crystal");
   xtal_pins_a: assert property (@(posedge mclk) disable iff (rst)
      src == obcl_pkg::SRC_XTAL |=> !osc_pin1_port && !osc_pin2_port)
      else $error("crystal pins released");
   held_rst_a: assert property (@(posedge mclk) disable iff (rst)
      !run |=> sys_reset) else $error("reset released before load");
   opt_hold_a: assert property (@(posedge mclk) disable iff (rst || pin_reset)
      run |=> $stable(opt_r)) else $error("option changed after load");
   ext_pins_a: assert property (@(posedge mclk) disable iff (rst)
      run && src == obcl_pkg::SRC_EXT |=> !osc_pin1_port && osc_pin2_port)
      else $error("external clock pin use wrong");
endmodule
`default_nettype wire

// ==== verif/obcl_flash_model.sv ====
// flash model serving the option byte at its fixed address
`default_nettype none
module obcl_flash_model (
   input wire logic mclk,
   input wire logic [15:0] flash_addr,
   input wire logic flash_rd,
   input wire logic [7:0] opt_byte,
   output logic [7:0] flash_rdata,
   output logic flash_rvalid
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   initial
   begin
      flash_rdata = 8'h00;
      flash_rvalid = 1'b0;
   end
   // a few cycles of read latency, so the loader must really wait
   always @(posedge mclk)
   begin
      flash_rvalid <= 1'b0;
      flash_rdata <= ~flash_rdata; // released bus never holds stale data
      cnt <= flash_rd ? cnt + 1 : 0;
      if (flash_rd && cnt == 3 && flash_addr == obcl_pkg::OPT_ADDR)
      begin
         flash_rvalid <= 1'b1;
         flash_rdata <= opt_byte;
      end
   end
endmodule
`default_nettype wire

// ==== verif/tb_option_byte_config_loader.sv ====
// self-checking bench for the option byte loader
`default_nettype none
module tb_option_byte_config_loader;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk, rst, reset_pin_raw, osc_tick, flash_rvalid, slow_osc_stop_request;
   logic wdt_sel_slow, cpu_halt, cpu_stop, flash_rd, sys_reset, load_done, reset_pin_keep;
   logic reset_pin_port_input, xtal_en, ext_clk_en, int_osc_sel, osc_pin1_port;
   logic osc_pin2_port, slow_osc_lock, slow_osc_run, wdt_clk_en, wdt_force_slow, tmh1_clk_en;
   logic [15:0] flash_addr;
   logic [7:0] flash_rdata, opt_byte;
   logic [1:0] settle_time_sel, clk_source_sel;
   int n_errors = 0;
   int checks_done = 0;
   int n;
   obcl_top obcl_top_i (.mclk, .rst, .reset_pin_raw, .osc_tick, .flash_rdata, .flash_rvalid,
      .slow_osc_stop_request, .wdt_sel_slow, .cpu_halt, .cpu_stop, .flash_addr, .flash_rd,
      .sys_reset, .load_done, .settle_time_sel, .reset_pin_keep, .reset_pin_port_input,
      .clk_source_sel, .xtal_en, .ext_clk_en, .int_osc_sel, .osc_pin1_port, .osc_pin2_port,
      .slow_osc_lock, .slow_osc_run, .wdt_clk_en, .wdt_force_slow, .tmh1_clk_en);
   obcl_flash_model obcl_flash_model_i (.mclk, .flash_addr, .flash_rd, .opt_byte, .flash_rdata,
      .flash_rvalid);
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic wt(input int lim);
      n = 0;
      while (load_done !== 1'b1 && n < lim)
      begin
         @(negedge mclk);
         n++;
      end
   endtask
   // reset held 5 cycles, then the load runs by itself
   task automatic boot(input logic [7:0] b, input int lim);
      @(negedge mclk);
      rst = 1'b1;
      opt_byte = b;
      repeat (5) @(negedge mclk);
      rst = 1'b0;
      wt(lim);
   endtask
   task automatic st(input logic [3:0] v);
      {slow_osc_stop_request, wdt_sel_slow, cpu_halt, cpu_stop} = v;
      repeat (3) @(negedge mclk);
   endtask
   initial
   begin
      #1_000_000;
      n_errors++;
      $display("watchdog expired");
      test_done();
   end
   initial
   begin
      {rst, reset_pin_raw, osc_tick, slow_osc_stop_request} = 4'b1111;
      {wdt_sel_slow, cpu_halt, cpu_stop} = 3'b100;
      opt_byte = 8'hFF;
      // osc_tick every cycle keeps the crystal waits short in cycles
      for (int s = 0; s < 4; s++)
      begin
         boot({1'b1, 2'(s), 1'b1, 1'b1, 2'(s), 1'b1}, 2000);
         chk("wait", 16'(s == 0), 16'(n >= 1024));
         chk("nowait", 1, 16'(n < 1100 && (s == 0 || n < 16)));
         chk("src", 16'(s), 16'(clk_source_sel));
         chk("pins", {s == 0, s == 1, s > 1, s > 1, s != 0},
            {xtal_en, ext_clk_en, int_osc_sel, osc_pin1_port, osc_pin2_port});
         chk("lock", 16'h0007, {slow_osc_run, wdt_force_slow, slow_osc_lock});
         chk("rst", 0, 16'(sys_reset));
      end
      boot(8'b1010_1001, 6000);
      chk("wait4k", 1, 16'(n >= 4096 && n < 4200));
      $display("sources done");
      boot(8'b1001_1110, 100);
      st(4'b1100);
      chk("stop", 0, {slow_osc_run, wdt_clk_en, wdt_force_slow});
      st(4'b0100);
      chk("run", 16'h0006, {slow_osc_run, wdt_clk_en, wdt_force_slow});
      st(4'b0110);
      chk("halt", 0, 16'(wdt_clk_en));
      st(4'b0000);
      chk("other", 0, 16'(wdt_clk_en));
      st(4'b0001);
      chk("tmh1", 16'h0002, {tmh1_clk_en, wdt_clk_en});
      $display("slow oscillator done");
      reset_pin_raw = 1'b0;
      boot(8'b1001_0111, 60);
      chk("held", 16'h0002, {sys_reset, load_done});
      reset_pin_raw = 1'b1;
      wt(100);
      opt_byte = 8'h00;
      reset_pin_raw = 1'b0;
      repeat (8) @(negedge mclk);
      chk("port", 16'h0007, {sys_reset, reset_pin_port_input, clk_source_sel});
      reset_pin_raw = 1'b1;
      boot(8'hFF, 100);
      reset_pin_raw = 1'b0;
      repeat (8) @(negedge mclk);
      chk("pinrst", 1, 16'(sys_reset));
      reset_pin_raw = 1'b1;
      $display("reset pin done");
      test_done();
   end
endmodule
`default_nettype wire
